//--- hw/dd_consts.svh
// register offsets, field positions, reset values and pin timing figures
// assumes inclusion by bare name from files that need the numbers
`ifndef DD_CONSTS_SVH
`define DD_CONSTS_SVH

`define DD_OFS_CTRL 8'h00
`define DD_OFS_OUT_A 8'h04
`define DD_OFS_OUT_B 8'h08
`define DD_OFS_STAGE_A 8'h0C
`define DD_OFS_STAGE_B 8'h10
`define DD_OFS_POWER 8'h14
`define DD_OFS_STATUS 8'h18
`define DD_OFS_LAST 8'h1C
`define DD_OFS_CMD 8'h20

`define DD_CTRL_LINK_EN 0
`define DD_CTRL_SW_ZERO 1
`define DD_CTRL_RESET 2'h1

`define DD_FR_CTL_HI 15
`define DD_FR_CTL_LO 13
`define DD_FR_PD 12
`define DD_FR_IMP_HI 11
`define DD_FR_IMP_LO 10
`define DD_FR_BITS 16
`define DD_CODE_BITS 12
`define DD_CODE_RESET 12'h000

`define DD_PWR_CH_STRIDE 4
`define DD_PWR_PD_BIT 2

`define DD_CLK_PERIOD_NS 100
`define DD_LINK_PERIOD_NS 800
`define DD_SYNC_PINS 5

`endif

//--- hw/dd_pkg.sv
// types shared by the serial command decoder and its pin synchroniser
// assumes dd_consts.svh for widths
`include "dd_consts.svh"

package dd_pkg;
    typedef logic [31:0] dd_word_t;
    typedef logic [`DD_CODE_BITS-1:0] dd_code_t;
    typedef logic [`DD_FR_BITS-1:0] dd_frame_t;

    typedef enum logic [1:0] {
        DD_IMP_FLOAT = 2'h0,
        DD_IMP_1K = 2'h1,
        DD_IMP_100K = 2'h2,
        DD_IMP_FLOAT_ALT = 2'h3
    } dd_imp_e;

    typedef enum logic [2:0] {
        DD_FR_IDLE = 3'h1,
        DD_FR_SHIFT = 3'h2,
        DD_FR_FULL = 3'h4
    } dd_frame_e;
endpackage

//--- hw/dd_pin_if.sv
// synchronised pin levels and edge pulses passed from the synchroniser to the decoder
// assumes both ends run on hclk
`timescale 1ns/1ps

interface dd_pin_if;
    logic fs_low;
    logic fs_fall;
    logic fs_rise;
    logic sck_fall;
    logic sdi_lvl;
    logic chain_lvl;
    logic zero_lvl;

    modport syncer (output fs_low, fs_fall, fs_rise, sck_fall, sdi_lvl, chain_lvl, zero_lvl);
    modport user (input fs_low, fs_fall, fs_rise, sck_fall, sdi_lvl, chain_lvl, zero_lvl);
endinterface

//--- hw/dd_pin_sync.sv
// two-flop synchronisers for the serial pins plus edge detection
// assumes pins are asynchronous to hclk and slow against it
`timescale 1ns/1ps
`include "dd_consts.svh"

module dd_pin_sync #(
    parameter int N = `DD_SYNC_PINS
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // raw pins: {async_zero_n, chain_enable, serial_in, serial_shift_clock, frame_select_n}
    input wire logic [N-1:0] pins,
    // synchronised view
    dd_pin_if.syncer sy
);
    import dd_pkg::*;

    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] prev_reg;

    // first stage feeds only the second; edges compare stages two and three
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                    prev_reg[i] <= 1'b1;
                end else if (ce) begin
                    meta_reg[i] <= pins[i];
                    sync_reg[i] <= meta_reg[i];
                    prev_reg[i] <= sync_reg[i];
                end
            end
        end
    endgenerate

    assign sy.fs_low = ~sync_reg[0];
    assign sy.fs_fall = prev_reg[0] & ~sync_reg[0];
    assign sy.fs_rise = ~prev_reg[0] & sync_reg[0];
    assign sy.sck_fall = prev_reg[1] & ~sync_reg[1];
    assign sy.sdi_lvl = sync_reg[2];
    assign sy.chain_lvl = sync_reg[3];
    assign sy.zero_lvl = sync_reg[4];
endmodule

//--- hw/dd_cmd_decoder.sv
// serial command decoder and output register logic for a two-channel converter
// assumes an ahb-lite master on hclk and a host serial master on asynchronous pins
//
// Notes on behaviour
// - frame starts on frame_select_n falling edge
// - async_zero_n low zeroes output registers asynchronously
// - control 000 stages channel A only
// - control 001 stages channel B only
// - control 010 stages and outputs channel A
// - control 011 loads A, copies B staging
// - control 100 stages and outputs channel B
// - control 101 loads B, copies A staging
// - control 110 loads both channels with data
// - control 111 copies both staging to outputs
// - power-down bit set selects impedance from 11..10
// - load_select 00 or 11 powers down both
// - load_select 01 powers down channel A only
// - load_select 10 powers down channel B only
// - sixteen bits msb first on falling shift clock
// - chain mode shifts on, serial_out delayed sixteen
// - after clear, wait for next frame rise
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dd_consts.svh"

module dd_cmd_decoder (
    // clock, reset, clock enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire dd_pkg::dd_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output dd_pkg::dd_word_t hrdata,
    // serial link pins
    input wire logic frame_select_n,
    input wire logic serial_shift_clock,
    input wire logic serial_in,
    input wire logic chain_enable,
    input wire logic async_zero_n,
    output logic serial_out,
    output logic serial_out_oe,
    // converter side
    output dd_pkg::dd_code_t out_code_a,
    output dd_pkg::dd_code_t out_code_b,
    output logic power_down_a,
    output logic power_down_b,
    output dd_pkg::dd_imp_e impedance_a,
    output dd_pkg::dd_imp_e impedance_b
);
    import dd_pkg::*;

    dd_pin_if pin();

    dd_pin_sync #(
        .N(`DD_SYNC_PINS)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pins({async_zero_n, chain_enable, serial_in, serial_shift_clock, frame_select_n}),
        .sy(pin)
    );

    // software register state
    logic [1:0] ctrl_reg;
    dd_frame_t sw_cmd_reg;
    logic sw_pend_reg;
    logic ph_wr_reg;
    logic [7:0] ph_addr_reg;
    dd_word_t hrdata_reg;

    // link state
    dd_frame_e fr_state_reg;
    dd_frame_e fr_state_next;
    dd_frame_t shift_reg;
    logic [4:0] bit_cnt_reg;
    dd_frame_t last_reg;
    logic [7:0] exec_cnt_reg;
    logic [7:0] abort_cnt_reg;

    // channel state, index 0 is channel A
    dd_code_t stage_reg [2];
    dd_code_t out_reg [2];
    logic pd_reg [2];
    dd_imp_e imp_reg [2];

    // clear path: pin or software zero, combined with the bus reset.
    // the pin acts without hclk so the outputs drop even with the clock stopped
    logic zero_n;
    assign zero_n = hresetn & async_zero_n & ~ctrl_reg[`DD_CTRL_SW_ZERO];

    // bus decode
    logic acc;
    logic wr_word;
    logic wr_ctrl;
    logic wr_cmd;
    assign acc = hsel & htrans[1] & hready & ce;
    assign wr_word = hwrite & (hsize == 3'h2);
    assign wr_ctrl = ph_wr_reg & ce & (ph_addr_reg == `DD_OFS_CTRL);
    assign wr_cmd = ph_wr_reg & ce & (ph_addr_reg == `DD_OFS_CMD);

    // link events
    logic link_en;
    logic chain;
    logic shift_en;
    logic full_now;
    logic link_exec;
    logic link_abort;
    assign link_en = ctrl_reg[`DD_CTRL_LINK_EN];
    assign chain = pin.chain_lvl;
    assign full_now = (fr_state_reg == DD_FR_FULL);
    // in chain mode the register keeps shifting past sixteen bits
    assign shift_en = link_en & pin.sck_fall & pin.fs_low & ~pin.fs_fall
        & ((fr_state_reg == DD_FR_SHIFT) | (full_now & chain));
    assign link_exec = link_en & pin.fs_rise & full_now;
    assign link_abort = link_en & pin.fs_rise & (fr_state_reg == DD_FR_SHIFT);

    // one frame is executed per cycle; a link frame wins and a software frame waits
    logic exec;
    logic sw_exec;
    dd_frame_t frame;
    assign sw_exec = sw_pend_reg & ~link_exec & ce;
    assign exec = (link_exec | sw_exec) & ce;
    assign frame = link_exec ? shift_reg : sw_cmd_reg;

    // control decode happens only on the frame's completing cycle
    logic [2:0] ctl;
    logic [1:0] load_sel;
    logic pd_cmd;
    logic normal;
    dd_code_t data;
    dd_imp_e imp_sel;
    assign ctl = frame[`DD_FR_CTL_HI:`DD_FR_CTL_LO];
    assign load_sel = frame[`DD_FR_CTL_HI:`DD_FR_CTL_HI-1];
    assign pd_cmd = exec & frame[`DD_FR_PD];
    assign normal = exec & ~frame[`DD_FR_PD];
    assign data = frame[`DD_CODE_BITS-1:0];
    assign imp_sel = dd_imp_e'(frame[`DD_FR_IMP_HI:`DD_FR_IMP_LO]);

    logic [1:0] wr_stage;
    logic [1:0] out_data;
    logic [1:0] out_copy;
    logic [1:0] pd_hit;
    assign wr_stage[0] = normal & ((ctl == 3'h0) | (ctl == 3'h2) | (ctl == 3'h3) | (ctl == 3'h6));
    assign wr_stage[1] = normal & ((ctl == 3'h1) | (ctl == 3'h4) | (ctl == 3'h5) | (ctl == 3'h6));
    assign out_data[0] = normal & ((ctl == 3'h2) | (ctl == 3'h3) | (ctl == 3'h6));
    assign out_data[1] = normal & ((ctl == 3'h4) | (ctl == 3'h5) | (ctl == 3'h6));
    assign out_copy[0] = normal & ((ctl == 3'h5) | (ctl == 3'h7));
    assign out_copy[1] = normal & ((ctl == 3'h3) | (ctl == 3'h7));
    // 01 selects A only, 10 selects B only, 00 and 11 select both
    assign pd_hit[0] = pd_cmd & (load_sel != 2'h2);
    assign pd_hit[1] = pd_cmd & (load_sel != 2'h1);

    // frame state machine
    always_comb begin
        fr_state_next = fr_state_reg;
        unique case (fr_state_reg)
            DD_FR_IDLE: begin
                if (link_en & pin.fs_fall) begin
                    fr_state_next = DD_FR_SHIFT;
                end
            end
            DD_FR_SHIFT: begin
                if (pin.fs_rise | ~link_en) begin
                    fr_state_next = DD_FR_IDLE;
                end else if (shift_en & (bit_cnt_reg == 5'(`DD_FR_BITS - 1))) begin
                    fr_state_next = DD_FR_FULL;
                end
            end
            DD_FR_FULL: begin
                if (pin.fs_rise | ~link_en) begin
                    fr_state_next = DD_FR_IDLE;
                end
            end
            default: begin
                fr_state_next = DD_FR_IDLE;
            end
        endcase
    end

    // the clear also drops any frame in flight, so nothing updates before
    // a fresh frame ends with its rising edge
    always_ff @(posedge hclk or negedge zero_n) begin
        if (!zero_n) begin
            fr_state_reg <= DD_FR_IDLE;
        end else if (ce) begin
            fr_state_reg <= fr_state_next;
        end
    end

    always_ff @(posedge hclk or negedge zero_n) begin
        if (!zero_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (ce) begin
            if (pin.fs_fall) begin
                bit_cnt_reg <= 5'h00;
            end else if (shift_en & (bit_cnt_reg != 5'(`DD_FR_BITS))) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // msb arrives first and ends up at bit 15
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= 16'h0000;
        end else if (ce & shift_en) begin
            shift_reg <= {shift_reg[`DD_FR_BITS-2:0], pin.sdi_lvl};
        end
    end

    // bit 15 holds the bit taken sixteen falling edges earlier
    assign serial_out = shift_reg[`DD_FR_BITS-1];
    assign serial_out_oe = chain;

    // per-channel registers
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            always_ff @(posedge hclk or negedge zero_n) begin
                if (!zero_n) begin
                    stage_reg[c] <= `DD_CODE_RESET;
                    out_reg[c] <= `DD_CODE_RESET;
                    pd_reg[c] <= 1'b0;
                    imp_reg[c] <= DD_IMP_FLOAT;
                end else if (ce) begin
                    if (wr_stage[c]) begin
                        stage_reg[c] <= data;
                    end
                    if (out_data[c]) begin
                        out_reg[c] <= data;
                    end else if (out_copy[c]) begin
                        out_reg[c] <= stage_reg[c];
                    end
                    if (pd_hit[c]) begin
                        pd_reg[c] <= 1'b1;
                        imp_reg[c] <= imp_sel;
                    end else if (out_data[c] | out_copy[c]) begin
                        pd_reg[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign out_code_a = out_reg[0];
    assign out_code_b = out_reg[1];
    assign power_down_a = pd_reg[0];
    assign power_down_b = pd_reg[1];
    assign impedance_a = imp_reg[0];
    assign impedance_b = imp_reg[1];

    // frame history counters survive the converter clear on purpose
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_reg <= 16'h0000;
            exec_cnt_reg <= 8'h00;
            abort_cnt_reg <= 8'h00;
        end else if (ce) begin
            if (exec) begin
                last_reg <= frame;
                exec_cnt_reg <= exec_cnt_reg + 8'h01;
            end
            if (link_abort) begin
                abort_cnt_reg <= abort_cnt_reg + 8'h01;
            end
        end
    end

    // bus address phase and data phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (ce) begin
            ph_wr_reg <= acc & wr_word;
            ph_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `DD_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= hwdata[1:0];
        end
    end

    // a software frame waits while a link frame executes; a new write wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_cmd_reg <= 16'h0000;
            sw_pend_reg <= 1'b0;
        end else if (ce) begin
            if (wr_cmd) begin
                sw_cmd_reg <= hwdata[`DD_FR_BITS-1:0];
                sw_pend_reg <= 1'b1;
            end else if (sw_exec) begin
                sw_pend_reg <= 1'b0;
            end
        end
    end

    // read mux, sampled in the address phase
    dd_word_t rd_mux;
    dd_word_t pwr_word;
    dd_word_t stat_word;
    assign pwr_word = {24'h000000,
        1'b0, pd_reg[1], imp_reg[1],
        1'b0, pd_reg[0], imp_reg[0]};
    assign stat_word = {abort_cnt_reg, exec_cnt_reg,
        5'h00, sw_pend_reg, pin.zero_lvl, chain, fr_state_reg, bit_cnt_reg};

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (haddr[7:0])
            `DD_OFS_CTRL: rd_mux = {30'h00000000, ctrl_reg};
            `DD_OFS_OUT_A: rd_mux = {20'h00000, out_reg[0]};
            `DD_OFS_OUT_B: rd_mux = {20'h00000, out_reg[1]};
            `DD_OFS_STAGE_A: rd_mux = {20'h00000, stage_reg[0]};
            `DD_OFS_STAGE_B: rd_mux = {20'h00000, stage_reg[1]};
            `DD_OFS_POWER: rd_mux = pwr_word;
            `DD_OFS_STATUS: rd_mux = stat_word;
            `DD_OFS_LAST: rd_mux = {16'h0000, last_reg};
            `DD_OFS_CMD: rd_mux = {16'h0000, sw_cmd_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (acc & ~hwrite) begin
            hrdata_reg <= rd_mux;
        end
    end

    // no wait states while running; a frozen block holds the bus
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
endmodule

//--- verification/dd_asserts.sv
// checker for the serial command decoder: clear, framing, power-down and chain pin behaviour
// assumes it is bound onto dd_cmd_decoder and that every check runs on hclk
`timescale 1ns/1ps

module dd_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // serial link pins
    input wire logic frame_select_n,
    input wire logic chain_enable,
    input wire logic async_zero_n,
    input wire logic serial_out_oe,
    // converter side
    input wire dd_pkg::dd_code_t out_code_a,
    input wire dd_pkg::dd_code_t out_code_b,
    input wire logic power_down_a,
    input wire logic power_down_b
);
    import dd_pkg::*;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_clear_zero_codes: assert property (!async_zero_n |-> out_code_a == 12'h000 && out_code_b == 12'h000)
        else $error("output codes not zero while clear is low");
    a_clear_no_pd: assert property (!async_zero_n |-> !power_down_a && !power_down_b)
        else $error("power-down left set while clear is low");
    // a frame needs far more than eight cycles, so nothing may load this soon
    a_clear_wait_frame: assert property ($rose(async_zero_n) |-> (out_code_a == 12'h000 && out_code_b == 12'h000) [*8])
        else $error("outputs updated before a frame completed after clear");
    a_pd_keeps_code_a: assert property ($rose(power_down_a) |-> $stable(out_code_a))
        else $error("power-down command altered channel a code");
    a_pd_keeps_code_b: assert property ($rose(power_down_b) |-> $stable(out_code_b))
        else $error("power-down command altered channel b code");
    a_update_ends_pd: assert property ($changed(out_code_a) && async_zero_n |-> ##[0:1] !power_down_a)
        else $error("channel a output update left it powered down");
    a_chain_oe_on: assert property (chain_enable [*6] |-> serial_out_oe)
        else $error("serial output not driven in chain mode");
    a_chain_oe_off: assert property (!chain_enable [*6] |-> !serial_out_oe)
        else $error("serial output driven outside chain mode");
    a_frame_low_hold: assert property ((!frame_select_n && async_zero_n) [*4] |->
        $stable(out_code_a) && $stable(out_code_b) && $stable(power_down_a) && $stable(power_down_b))
        else $error("outputs changed while a frame was in flight");

    cover property (!power_down_a && power_down_b);
    cover property ($rose(serial_out_oe));
    cover property ($fell(async_zero_n));
endmodule

bind dd_cmd_decoder dd_asserts dd_asserts_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .frame_select_n(frame_select_n),
    .chain_enable(chain_enable),
    .async_zero_n(async_zero_n),
    .serial_out_oe(serial_out_oe),
    .out_code_a(out_code_a),
    .out_code_b(out_code_b),
    .power_down_a(power_down_a),
    .power_down_b(power_down_b)
);

//--- verification/dd_host_model.sv
// host serial master model: frame strobe, shift clock and data, msb first
// assumes the device samples data on falling shift clock edges while the strobe is low
`timescale 1ns/1ps

module dd_host_model #(
    parameter int HALF_CYC = 4
) (
    // clock the pins are launched from
    input wire logic hclk,
    // serial pins toward the device
    output logic frame_select_n,
    output logic serial_shift_clock,
    output logic serial_in
);
    // shift clock idles high and stands still between frames
    initial begin
        frame_select_n = 1'h1;
        serial_shift_clock = 1'h1;
        serial_in = 1'h0;
    end

    // n below 16 gives a short frame; pins move just after hclk edges, half a link period apart
    task automatic send(input logic [31:0] bits, input int n);
        @(posedge hclk);
        frame_select_n <= 1'h0;
        repeat (HALF_CYC) @(posedge hclk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= bits[i];
            repeat (HALF_CYC) @(posedge hclk);
            serial_shift_clock <= 1'h0;
            repeat (HALF_CYC) @(posedge hclk);
            serial_shift_clock <= 1'h1;
        end
        repeat (HALF_CYC) @(posedge hclk);
        frame_select_n <= 1'h1;
        // a released data line must not keep showing the last bit
        serial_in <= ~serial_in;
        repeat (2 * HALF_CYC) @(posedge hclk);
    endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench for the serial command decoder behind a host serial model
// assumes dd_pkg, the design files, dd_host_model and dd_asserts are compiled first
`timescale 1ns/1ps
`include "dd_consts.svh"

`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module tb_top;
    import dd_pkg::*;

    // clock, reset and bus
    logic hclk;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    dd_word_t hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    dd_word_t hrdata;
    // link pins and converter side
    logic frame_select_n;
    logic serial_shift_clock;
    logic serial_in;
    logic chain_enable = 1'h0;
    logic async_zero_n = 1'h1;
    logic serial_out;
    logic serial_out_oe;
    dd_code_t out_code_a;
    dd_code_t out_code_b;
    logic power_down_a;
    logic power_down_b;
    dd_imp_e impedance_a;
    dd_imp_e impedance_b;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    dd_cmd_decoder dd_cmd_decoder_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_select_n(frame_select_n),
        .serial_shift_clock(serial_shift_clock), .serial_in(serial_in), .chain_enable(chain_enable),
        .async_zero_n(async_zero_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .out_code_a(out_code_a), .out_code_b(out_code_b), .power_down_a(power_down_a),
        .power_down_b(power_down_b), .impedance_a(impedance_a), .impedance_b(impedance_b));

    dd_host_model dd_host_model_inst (.hclk(hclk), .frame_select_n(frame_select_n),
        .serial_shift_clock(serial_shift_clock), .serial_in(serial_in));

    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a run that never ends counts against the design
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            test_done();
        end
    end

    // single word transfer; the address phase is held until hready is seen high
    task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input dd_word_t wdata, output dd_word_t rdata);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rdata = hrdata;
    endtask

    // impedance is only meaningful while its channel is powered down
    task automatic frame_check(input logic [31:0] bits, input int n, input logic [23:0] exp_codes,
        input logic [5:0] exp_pd);
        logic [5:0] got_pd;
        dd_host_model_inst.send(bits, n);
        repeat (6) @(posedge hclk);
        got_pd = {power_down_a, power_down_b, {2{power_down_a}} & impedance_a, {2{power_down_b}} & impedance_b};
        `CHK({out_code_a, out_code_b}, exp_codes);
        `CHK(got_pd, exp_pd);
    endtask

    task automatic t_normal();
        logic [15:0] fr [10] = '{16'h0111, 16'h2222, 16'h4333, 16'h6444, 16'h8555, 16'hA666, 16'hC777,
            16'h00AB, 16'h20CD, 16'hEFFF};
        logic [23:0] ex [10] = '{24'h000000, 24'h000000, 24'h333000, 24'h444222, 24'h444555, 24'h444666,
            24'h777777, 24'h777777, 24'h777777, 24'h0AB0CD};
        for (int i = 0; i < 10; i++) begin
            frame_check({16'h0000, fr[i]}, 16, ex[i], 6'h00);
        end
    endtask

    task automatic t_power();
        logic [15:0] fr [7] = '{16'h37FF, 16'h4123, 16'h5800, 16'h9C00, 16'hF000, 16'h1800, 16'hEFFF};
        logic [5:0] ex [7] = '{6'h35, 6'h11, 6'h39, 6'h3B, 6'h30, 6'h3A, 6'h00};
        frame_check({16'h0000, fr[0]}, 16, 24'h0AB0CD, ex[0]);
        for (int i = 1; i < 7; i++) begin
            frame_check({16'h0000, fr[i]}, 16, 24'h1230CD, ex[i]);
        end
    endtask

    // leftover shift bits would decode as a power-down if the short frame ran
    task automatic t_abort();
        frame_check(32'h0000_0000, 10, 24'h1230CD, 6'h00);
        `CHK(serial_out_oe, 1'h0);
        frame_check(32'h0000_4456, 16, 24'h4560CD, 6'h00);
    endtask

    task automatic t_chain();
        chain_enable <= 1'h1;
        repeat (6) @(posedge hclk);
        `CHK(serial_out_oe, 1'h1);
        // only the last sixteen bits count; the first word would leave channel b alone
        frame_check(32'h4321_C321, 32, 24'h321321, 6'h00);
        `CHK(serial_out, 1'h1);
        chain_enable <= 1'h0;
        repeat (6) @(posedge hclk);
        `CHK(serial_out_oe, 1'h0);
    endtask

    task automatic t_clear();
        frame_check(32'h0000_37FF, 16, 24'h321321, 6'h35);
        async_zero_n <= 1'h0;
        #1;
        `CHK({out_code_a, out_code_b, power_down_a, power_down_b}, 26'h0);
        repeat (3) @(posedge hclk);
        async_zero_n <= 1'h1;
        repeat (10) @(posedge hclk);
        `CHK({out_code_a, out_code_b}, 24'h000000);
        frame_check(32'h0000_4ABC, 16, 24'hABC000, 6'h00);
    endtask

    task automatic t_bus();
        dd_word_t rd;
        // write a value unlike the reset value so the write is really seen
        ahb_xfer(1'h1, {24'h000000, `DD_OFS_CTRL}, 32'h0000_0000, rd);
        ahb_xfer(1'h0, {24'h000000, `DD_OFS_CTRL}, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000);
        ahb_xfer(1'h1, {24'h000000, `DD_OFS_CTRL}, 32'h0000_0001, rd);
        ahb_xfer(1'h0, {24'h000000, `DD_OFS_CTRL}, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0001);
        ahb_xfer(1'h0, {24'h000000, `DD_OFS_OUT_A}, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0ABC);
        ahb_xfer(1'h0, {24'h000000, `DD_OFS_LAST}, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_4ABC);
        // a software frame goes through the same decode as a serial one
        ahb_xfer(1'h1, {24'h000000, `DD_OFS_CMD}, 32'h0000_C456, rd);
        repeat (2) @(posedge hclk);
        `CHK({out_code_a, out_code_b}, 24'h456456);
        ahb_xfer(1'h0, 32'h0000_0040, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000);
        `CHK(hresp, 1'h0);
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        t_normal();
        t_power();
        t_abort();
        t_chain();
        t_clear();
        t_bus();
        test_done();
    end
endmodule
